// ---- include/wdr_pkg.sv ----
// Package for the watchdog and reset control block.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone register bus.
package wdr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] WDR_ADR_WDOG_CTRL = 8'h00;
  localparam logic [7:0] WDR_ADR_RST_FLAGS = 8'h04;
  localparam logic [7:0] WDR_ADR_UV_CTRL = 8'h08;
  localparam logic [7:0] WDR_ADR_STATUS = 8'h0C;
  localparam logic [7:0] WDR_ADR_PORT_DATA = 8'h10;
  localparam logic [7:0] WDR_ADR_PORT_DIR = 8'h14;

  // ----------------------------------------------------------------
  // Fields, codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WDR_WDOG_CTRL_POR = 8'h53;
  localparam logic [4:0] WDR_WKEY_DISABLE = 5'h15;
  localparam logic [4:0] WDR_WKEY_ENABLE = 5'h0A;
  localparam logic [7:0] WDR_UV_CTRL_POR = 8'h5A;
  localparam logic [7:0] WDR_UKEY_FIXED = 8'h5A;
  localparam logic [7:0] WDR_UKEY_DISABLE = 8'hA5;
  localparam logic [7:0] WDR_PORT_POR = 8'hFF;
  localparam int WDR_KEY_LSB = 3;
  localparam int WDR_PERIOD_BASE_LOG2 = 8;
  localparam int WDR_WDOG_CNT_W = 16;
  localparam int WDR_FLAG_WDOG_BIT = 0;
  localparam int WDR_FLAG_LVCTRL_BIT = 1;
  localparam int WDR_FLAG_UV_BIT = 2;
  localparam int WDR_STAT_EXPIRY_BIT = 0;
  localparam int WDR_STAT_PDOWN_BIT = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int WDR_CLK_PERIOD_PS = 5000;
  localparam int WDR_SRESET_DELAY_NS = 1000;
  localparam int WDR_UV_MIN_NS = 120000;
  localparam int WDR_SRESET_CYC =
    (WDR_SRESET_DELAY_NS * 1000 + WDR_CLK_PERIOD_PS - 1) / WDR_CLK_PERIOD_PS;
  localparam int WDR_UV_MIN_CYC =
    (WDR_UV_MIN_NS * 1000 + WDR_CLK_PERIOD_PS - 1) / WDR_CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KEY_ON, KEY_OFF, KEY_BAD} wdr_key_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wdr_wb_req_t;

  typedef struct packed {
    logic wdog_ctrl_reset_flag;
    logic lv_ctrl_reset_flag;
    logic undervoltage_reset_flag;
  } wdr_src_t;

  typedef struct packed {
    logic expiry_flag;
    logic powerdown_flag;
  } wdr_stat_t;

endpackage

// ---- rtl/wdr_top.sv ----
// Watchdog timer with guarded keys, reset source flags and undervoltage
// reset qualification, as a classic Wishbone slave.
// Assumes slow oscillator, core events and supply monitor are synchronous
// to mclk_in; sys_rst_in is the power-on reset.
//
// Operation
// [RULE_01] Key 10101 disables the watchdog, key 01010 enables it.
// [RULE_02] Any other watchdog key resets the device after delay, setting its flag.
// [RULE_03] After power-on the watchdog key holds the enable code.
// [RULE_04] Period select picks 2^8 to 2^15 slow oscillator periods.
// [RULE_05] Watchdog control register powers up as 0x53.
// [RULE_06] Watchdog key flag set by hardware, cleared only by software, zero at power-on.
// [RULE_07] Reset flag bits 7 to 3 read as zero.
// [RULE_08] Overflow while running gives full device reset and sets expiry flag.
// [RULE_09] Overflow in low power sets expiry and powerdown, resets only PC and SP.
// [RULE_10] Counter cleared by key reset, clear instruction or stop instruction.
// [RULE_11] Power-on reset sets program counter to zero.
// [RULE_12] Power-on reset sets port data and direction registers to all ones.
// [RULE_13] Enabled undervoltage detection in running modes resets and sets its flag.
// [RULE_14] Low supply must persist longer than minimum duration to act.
// [RULE_15] Undervoltage key other than two codes resets after delay, sets its flag.
// [RULE_16] Undervoltage control powers up with the fixed threshold code.
// [RULE_17] Undervoltage detection disabled in sleep or idle.
// [RULE_18] Stop sets powerdown flag; power-up or clear instruction clears it.
// [RULE_19] Entering low power clears the watchdog; it resumes only if enabled.
// [RULE_20] Counter steps per slow oscillator cycle, overflows at selected count, restarts.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module wdr_top
  import wdr_pkg::*;
#(
  parameter int SRESET_CYC = WDR_SRESET_CYC,
  parameter int UV_MIN_CYC = WDR_UV_MIN_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Wishbone slave
  input wire wdr_wb_req_t wb_req_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  // Core events and levels
  input wire logic slow_osc_in,
  input wire logic clear_wdog_in,
  input wire logic stop_in,
  input wire logic low_power_in,
  input wire logic low_supply_in,
  // Reset actions
  output logic device_reset_out,
  output logic pc_sp_clear_out,
  output wdr_stat_t status_out,
  output logic [7:0] port_data_out,
  output logic [7:0] port_dir_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [WDR_WDOG_CNT_W-1:0] period_last(input logic [2:0] sel);
    logic [WDR_WDOG_CNT_W:0] full;
    full = '0;
    full[WDR_PERIOD_BASE_LOG2 + int'(sel)] = 1'b1;
    period_last = WDR_WDOG_CNT_W'(full - 1'b1);
  endfunction

  function automatic wdr_key_t wkey_decode(input logic [4:0] key);
    if (key == WDR_WKEY_ENABLE) begin
      wkey_decode = KEY_ON;
    end else if (key == WDR_WKEY_DISABLE) begin
      wkey_decode = KEY_OFF;
    end else begin
      wkey_decode = KEY_BAD;
    end
  endfunction

  function automatic wdr_key_t ukey_decode(input logic [7:0] key);
    if (key == WDR_UKEY_FIXED) begin
      ukey_decode = KEY_ON;
    end else if (key == WDR_UKEY_DISABLE) begin
      ukey_decode = KEY_OFF;
    end else begin
      ukey_decode = KEY_BAD;
    end
  endfunction

  localparam int SR_W = $clog2(SRESET_CYC + 1);
  localparam int UV_W = $clog2(UV_MIN_CYC + 2);
  localparam logic [SR_W-1:0] SR_LAST = SR_W'(SRESET_CYC - 1);
  localparam logic [UV_W-1:0] UV_FIRE = UV_W'(UV_MIN_CYC);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] wdog_ctrl;
  logic [7:0] uv_ctrl;
  wdr_src_t src;
  wdr_stat_t stat;
  logic [WDR_WDOG_CNT_W-1:0] wdog_cnt;
  logic slow_q;
  logic low_power_q;
  logic [SR_W-1:0] wkey_cnt;
  logic [SR_W-1:0] ukey_cnt;
  logic [UV_W-1:0] uv_cnt;
  logic uv_done;
  logic wkey_fire;
  logic ukey_fire;
  logic uv_fire;
  logic wdog_ovf;
  wdr_key_t wkey;
  wdr_key_t ukey;

  logic bus_req;
  logic bus_wr;
  logic wr_wdog;
  logic wr_uv;
  logic wr_flags;
  logic wr_pdata;
  logic wr_pdir;
  logic slow_tick;
  logic full_reset;
  logic low_power_entry;

  assign bus_req = wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
  assign bus_wr = bus_req && wb_req_in.we && wb_req_in.sel[0];
  assign wr_wdog = bus_wr && (wb_req_in.adr == WDR_ADR_WDOG_CTRL);
  assign wr_flags = bus_wr && (wb_req_in.adr == WDR_ADR_RST_FLAGS);
  assign wr_uv = bus_wr && (wb_req_in.adr == WDR_ADR_UV_CTRL);
  assign wr_pdata = bus_wr && (wb_req_in.adr == WDR_ADR_PORT_DATA);
  assign wr_pdir = bus_wr && (wb_req_in.adr == WDR_ADR_PORT_DIR);

  assign wkey = wkey_decode(wdog_ctrl[7:WDR_KEY_LSB]);
  assign ukey = ukey_decode(uv_ctrl);
  assign slow_tick = slow_osc_in && !slow_q;
  assign low_power_entry = low_power_in && !low_power_q;
  // A clear, stop or low-power entry on the same tick wins over the overflow
  assign wdog_ovf = (wkey == KEY_ON) && slow_tick && !low_power_entry && !clear_wdog_in &&
    !stop_in && (wdog_cnt == period_last(wdog_ctrl[WDR_KEY_LSB-1:0])); // RULE_20 RULE_04
  assign full_reset = wkey_fire || ukey_fire || uv_fire || (wdog_ovf && !low_power_in);

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= bus_req;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wb_dat_out <= '0;
    end else if (bus_req && !wb_req_in.we) begin
      wb_dat_out <= '0;
      unique case (wb_req_in.adr)
        WDR_ADR_WDOG_CTRL: wb_dat_out[7:0] <= wdog_ctrl;
        WDR_ADR_RST_FLAGS: begin
          wb_dat_out[WDR_FLAG_WDOG_BIT] <= src.wdog_ctrl_reset_flag; // RULE_07
          wb_dat_out[WDR_FLAG_LVCTRL_BIT] <= src.lv_ctrl_reset_flag;
          wb_dat_out[WDR_FLAG_UV_BIT] <= src.undervoltage_reset_flag;
        end
        WDR_ADR_UV_CTRL: wb_dat_out[7:0] <= uv_ctrl;
        WDR_ADR_STATUS: begin
          wb_dat_out[WDR_STAT_EXPIRY_BIT] <= stat.expiry_flag;
          wb_dat_out[WDR_STAT_PDOWN_BIT] <= stat.powerdown_flag;
        end
        WDR_ADR_PORT_DATA: wb_dat_out[7:0] <= port_data_out;
        WDR_ADR_PORT_DIR: wb_dat_out[7:0] <= port_dir_out;
        default: wb_dat_out <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wdog_ctrl <= WDR_WDOG_CTRL_POR; // RULE_03 RULE_05
    end else if (wkey_fire) begin
      wdog_ctrl <= WDR_WDOG_CTRL_POR;
    end else if (wr_wdog) begin
      wdog_ctrl <= wb_req_in.dat[7:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      uv_ctrl <= WDR_UV_CTRL_POR; // RULE_16
    end else if (ukey_fire) begin
      uv_ctrl <= WDR_UV_CTRL_POR;
    end else if (wr_uv) begin
      uv_ctrl <= wb_req_in.dat[7:0];
    end
  end

  // Port registers come up as inputs on every full reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || full_reset) begin
      port_data_out <= WDR_PORT_POR; // RULE_12
      port_dir_out <= WDR_PORT_POR; // RULE_12
    end else begin
      if (wr_pdata) begin
        port_data_out <= wb_req_in.dat[7:0];
      end
      if (wr_pdir) begin
        port_dir_out <= wb_req_in.dat[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Software reset delays for bad keys
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || wkey != KEY_BAD) begin
      wkey_cnt <= '0;
      wkey_fire <= 1'b0;
    end else begin
      // One pulse: the key register is restored on the firing cycle
      wkey_fire <= (wkey_cnt == SR_LAST) && !wkey_fire; // RULE_02
      if (wkey_cnt != SR_LAST) begin
        wkey_cnt <= wkey_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || ukey != KEY_BAD) begin
      ukey_cnt <= '0;
      ukey_fire <= 1'b0;
    end else begin
      // One pulse: the key register is restored on the firing cycle
      ukey_fire <= (ukey_cnt == SR_LAST) && !ukey_fire; // RULE_15
      if (ukey_cnt != SR_LAST) begin
        ukey_cnt <= ukey_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Undervoltage qualification
  // ----------------------------------------------------------------
  // Any gap in the low-supply level restarts the qualification
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !low_supply_in || ukey != KEY_ON || low_power_in) begin // RULE_17
      uv_cnt <= '0; // RULE_14
      uv_done <= 1'b0;
      uv_fire <= 1'b0;
    end else begin
      uv_fire <= 1'b0;
      if (uv_cnt != UV_FIRE) begin
        uv_cnt <= uv_cnt + 1'b1;
      end else if (!uv_done) begin
        uv_fire <= 1'b1; // RULE_13
        uv_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      slow_q <= 1'b0;
      low_power_q <= 1'b0;
    end else begin
      slow_q <= slow_osc_in;
      low_power_q <= low_power_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || full_reset || wdog_ovf) begin
      wdog_cnt <= '0; // RULE_10 RULE_20
    end else if (clear_wdog_in || stop_in || low_power_entry) begin
      wdog_cnt <= '0; // RULE_10 RULE_19
    end else if (wkey == KEY_ON && slow_tick) begin
      wdog_cnt <= wdog_cnt + 1'b1; // RULE_01 RULE_19
    end
  end

  // ----------------------------------------------------------------
  // Status and reset source flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      stat <= '0; // RULE_18
    end else begin
      if (clear_wdog_in) begin
        stat.powerdown_flag <= 1'b0; // RULE_18
      end
      if (stop_in) begin
        stat.powerdown_flag <= 1'b1; // RULE_18
        stat.expiry_flag <= 1'b0;
      end
      if (wdog_ovf) begin
        stat.expiry_flag <= 1'b1; // RULE_08
        if (low_power_in) begin
          stat.powerdown_flag <= 1'b1; // RULE_09
        end
      end
    end
  end

  assign status_out = stat;

  // Software clears with a written 0; a hardware set in the same cycle wins
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      src <= '0; // RULE_06
    end else begin
      if (wr_flags && !wb_req_in.dat[WDR_FLAG_WDOG_BIT]) begin
        src.wdog_ctrl_reset_flag <= 1'b0;
      end
      if (wr_flags && !wb_req_in.dat[WDR_FLAG_LVCTRL_BIT]) begin
        src.lv_ctrl_reset_flag <= 1'b0;
      end
      if (wr_flags && !wb_req_in.dat[WDR_FLAG_UV_BIT]) begin
        src.undervoltage_reset_flag <= 1'b0;
      end
      if (wkey_fire) begin
        src.wdog_ctrl_reset_flag <= 1'b1; // RULE_02 RULE_06
      end
      if (ukey_fire) begin
        src.lv_ctrl_reset_flag <= 1'b1; // RULE_15
      end
      if (uv_fire) begin
        src.undervoltage_reset_flag <= 1'b1; // RULE_13
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      device_reset_out <= 1'b0;
      pc_sp_clear_out <= 1'b1; // RULE_11
    end else begin
      device_reset_out <= full_reset; // RULE_08
      // Low-power overflow clears only the program counter and stack pointer
      pc_sp_clear_out <= full_reset || wdog_ovf; // RULE_09 RULE_11
    end
  end

endmodule

// ---- dv/wdr_properties.sv ----
// Concurrent checks for the watchdog and reset control block.
// Assumes it is bound to wdr_top and sees only that module's ports.
`timescale 1ns/1ps
module wdr_properties
  import wdr_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire wdr_wb_req_t wb_req_in,
  input wire logic wb_ack_out,
  input wire logic clear_wdog_in,
  input wire logic stop_in,
  input wire logic device_reset_out,
  input wire logic pc_sp_clear_out,
  input wire wdr_stat_t status_out,
  input wire logic [7:0] port_data_out,
  input wire logic [7:0] port_dir_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  ack_latency_a: assert property (disable iff (sys_rst_in)
    wb_req_in.cyc && wb_req_in.stb && !wb_ack_out |=> wb_ack_out) else $error("ack late");
  ack_pulse_a: assert property (disable iff (sys_rst_in)
    wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  por_pc_a: assert property (sys_rst_in |=> pc_sp_clear_out)
    else $error("pc clear missing in reset");
  por_ports_a: assert property (sys_rst_in |=> port_data_out == 8'hFF &&
    port_dir_out == 8'hFF) else $error("ports not all ones after reset");
  por_status_a: assert property (sys_rst_in |=> status_out == '0)
    else $error("status not zero after reset");
  full_reset_a: assert property (disable iff (sys_rst_in) device_reset_out |->
    pc_sp_clear_out ##1 (!device_reset_out && port_data_out == 8'hFF && port_dir_out == 8'hFF))
    else $error("full reset action wrong");
  stop_flags_a: assert property (disable iff (sys_rst_in) stop_in |=>
    status_out.powerdown_flag && !status_out.expiry_flag) else $error("stop flags wrong");
  clear_pdown_a: assert property (disable iff (sys_rst_in) clear_wdog_in && !stop_in |=>
    !status_out.powerdown_flag) else $error("clear left powerdown set");
  expiry_reset_a: assert property (disable iff (sys_rst_in)
    $rose(status_out.expiry_flag) |-> pc_sp_clear_out) else $error("expiry without pc clear");
endmodule

bind wdr_top wdr_properties wdr_properties_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
  .wb_req_in(wb_req_in), .wb_ack_out(wb_ack_out), .clear_wdog_in(clear_wdog_in),
  .stop_in(stop_in), .device_reset_out(device_reset_out), .pc_sp_clear_out(pc_sp_clear_out),
  .status_out(status_out), .port_data_out(port_data_out), .port_dir_out(port_dir_out));

// ---- dv/tb.sv ----
// Self-checking bench for the watchdog and reset control block.
// Assumes the bench drives every port of wdr_top itself over a 200 MHz clock.
`timescale 1ns/1ps
module tb;
  import wdr_pkg::*;
  localparam int SR = 4;
  localparam int UV = 8;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  wdr_wb_req_t req = '0;
  logic slow = 1'b0, clr = 1'b0, stp = 1'b0, lp = 1'b0, lows = 1'b0;
  logic ack, drst, pcs;
  logic [31:0] dat;
  wdr_stat_t stat;
  logic [7:0] pdat, pdir, rd, v;
  logic [4:0] key;
  logic [31:0] seed = 32'h73e3_ab8e;
  int error_cnt = 0, n_compared = 0, rst_seen = 0, pcs_seen = 0, r0, p0, k;
  logic [7:0] adr_t [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  logic [7:0] por_t [7] = '{8'h53, 8'h00, 8'h5A, 8'h00, 8'hFF, 8'hFF, 8'h00};
  wdr_top #(.SRESET_CYC(SR), .UV_MIN_CYC(UV)) wdr_top_inst (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .wb_req_in(req), .wb_ack_out(ack), .wb_dat_out(dat),
    .slow_osc_in(slow), .clear_wdog_in(clr), .stop_in(stp), .low_power_in(lp),
    .low_supply_in(lows), .device_reset_out(drst), .pc_sp_clear_out(pcs), .status_out(stat),
    .port_data_out(pdat), .port_dir_out(pdir));
  initial forever #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (drst === 1'b1) rst_seen++;
    if (pcs === 1'b1 && sys_rst_in === 1'b0) pcs_seen++;
  end
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int period(input int s);
    return 1 << (WDR_PERIOD_BASE_LOG2 + s);
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    bit got;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: {24'h00_0000, d}};
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    got = (ack === 1'b1);
    q = dat[7:0];
    req <= '0;
    @(posedge mclk_in);
    if (!got) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      slow <= 1'b1;
      @(posedge mclk_in);
      slow <= 1'b0;
      @(posedge mclk_in);
    end
  endtask
  initial begin
    repeat (100000) @(posedge mclk_in);
    error_cnt++;
    tally_and_finish();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    cyc(12);
    sys_rst_in <= 1'b0;
    cyc(1);
    foreach (adr_t[j]) rdchk(adr_t[j], por_t[j]);
    for (k = 0; k < 2; k++) begin
      wb(1'b1, WDR_ADR_WDOG_CTRL, {WDR_WKEY_ENABLE, 3'(k)}, rd);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      r0 = rst_seen;
      tick(period(k) - 1);
      chk(rst_seen, r0);
      tick(1);
      cyc(3);
      chk(rst_seen, r0 + 1);
      rdchk(WDR_ADR_STATUS, 8'h01);
    end
    wb(1'b1, WDR_ADR_WDOG_CTRL, {WDR_WKEY_DISABLE, 3'b000}, rd);
    r0 = rst_seen;
    tick(300);
    chk(rst_seen, r0);
    for (k = 0; k < 3; k++) begin
      v = 8'(xs());
      key = v[4:0];
      if (key == WDR_WKEY_ENABLE || key == WDR_WKEY_DISABLE) key = key ^ 5'h01;
      wb(1'b1, WDR_ADR_PORT_DIR, v & 8'h7F, rd);
      rdchk(WDR_ADR_PORT_DIR, v & 8'h7F);
      wb(1'b1, WDR_ADR_PORT_DATA, v & 8'h7F, rd);
      rdchk(WDR_ADR_PORT_DATA, v & 8'h7F);
      r0 = rst_seen;
      wb(1'b1, WDR_ADR_WDOG_CTRL, {key, 3'b001}, rd);
      cyc(SR + 3);
      chk(rst_seen, r0 + 1);
      chk(pdir, 8'hFF);
      chk(pdat, WDR_PORT_POR);
      rdchk(WDR_ADR_WDOG_CTRL, WDR_WDOG_CTRL_POR);
      wb(1'b1, WDR_ADR_RST_FLAGS, 8'hFF, rd);
      rdchk(WDR_ADR_RST_FLAGS, 8'h01);
      wb(1'b1, WDR_ADR_RST_FLAGS, 8'h00, rd);
      rdchk(WDR_ADR_RST_FLAGS, 8'h00);
    end
    v = 8'(xs());
    if (v == WDR_UKEY_FIXED || v == WDR_UKEY_DISABLE) v = v ^ 8'h01;
    r0 = rst_seen;
    wb(1'b1, WDR_ADR_UV_CTRL, v, rd);
    cyc(SR + 3);
    chk(rst_seen, r0 + 1);
    rdchk(WDR_ADR_UV_CTRL, WDR_UV_CTRL_POR);
    rdchk(WDR_ADR_RST_FLAGS, 8'h02);
    wb(1'b1, WDR_ADR_RST_FLAGS, 8'h00, rd);
    wb(1'b1, WDR_ADR_WDOG_CTRL, {WDR_WKEY_ENABLE, 3'b000}, rd);
    stp <= 1'b1;
    cyc(1);
    stp <= 1'b0;
    rdchk(WDR_ADR_STATUS, 8'h02);
    chk({31'h0, stat.powerdown_flag}, 32'h0000_0001);
    chk({31'h0, stat.expiry_flag}, 32'h0000_0000);
    lp <= 1'b1;
    cyc(1);
    r0 = rst_seen;
    p0 = pcs_seen;
    tick(period(0));
    cyc(3);
    chk(rst_seen, r0);
    chk(pcs_seen, p0 + 1);
    rdchk(WDR_ADR_STATUS, 8'h03);
    chk({30'h0, stat}, 32'h0000_0003);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    rdchk(WDR_ADR_STATUS, 8'h01);
    lows <= 1'b1;
    cyc(UV + 10);
    lows <= 1'b0;
    chk(rst_seen, r0);
    lp <= 1'b0;
    cyc(2);
    wb(1'b1, WDR_ADR_UV_CTRL, WDR_UKEY_DISABLE, rd);
    lows <= 1'b1;
    cyc(UV + 6);
    lows <= 1'b0;
    chk(rst_seen, r0);
    wb(1'b1, WDR_ADR_UV_CTRL, WDR_UKEY_FIXED, rd);
    lows <= 1'b1;
    cyc(UV);
    lows <= 1'b0;
    cyc(4);
    chk(rst_seen, r0);
    lows <= 1'b1;
    cyc(UV + 6);
    chk(rst_seen, r0 + 1);
    lows <= 1'b0;
    rdchk(WDR_ADR_RST_FLAGS, 8'h04);
    sys_rst_in <= 1'b1;
    cyc(2);
    sys_rst_in <= 1'b0;
    cyc(1);
    rdchk(WDR_ADR_RST_FLAGS, 8'h00);
    rdchk(WDR_ADR_STATUS, 8'h00);
    rdchk(WDR_ADR_WDOG_CTRL, WDR_WDOG_CTRL_POR);
    tally_and_finish();
  end
endmodule
